// ### rtl/status_summary_pkg.sv
// Constants shared by the status summary register set
package status_summary_pkg;
   // ---------------------------------------------
   // Command codes
   // ---------------------------------------------
   localparam logic [7:0] CMD_CRIT_SUMMARY = 8'h78;
   localparam logic [7:0] CMD_FAULT_WORD   = 8'h79;
   localparam logic [7:0] CMD_OUTPUT_FLAGS = 8'h7A;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   // ---------------------------------------------
   // Summary byte field positions
   // ---------------------------------------------
   localparam int BIT_BUSY      = 7;
   localparam int BIT_GATE_OFF  = 6;
   localparam int BIT_VIN_UV    = 3;
   localparam int BIT_TEMP      = 2;
   localparam int BIT_CML       = 1;
   localparam int BIT_OTHER     = 0;
   // ---------------------------------------------
   // Summary word high-byte field positions
   // ---------------------------------------------
   localparam int BIT_OUT_SUM   = 15;
   localparam int BIT_IOUT_SUM  = 14;
   localparam int BIT_INPUT_SUM = 13;
   localparam int BIT_VEND_SUM  = 12;
   localparam int BIT_PGOOD_N   = 11;
   localparam int BIT_UNLISTED  = 8;
   // ---------------------------------------------
   // Output status field position and reset values
   // ---------------------------------------------
   localparam int BIT_VOUT_UV   = 5;
   localparam logic [7:0]  RST_CRIT_SUMMARY = 8'h00;
   localparam logic [15:0] RST_FAULT_WORD   = 16'h0800;
   localparam logic [7:0]  RST_OUTPUT_FLAGS = 8'h00;
   localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;
endpackage

// ### rtl/status_flag_if.sv
// Interface carrying raw fault levels and clear strobe to the sticky flag store
`timescale 1ns/1ps
interface status_flag_if;
   logic        clearReq;
   logic [15:0] rawLevels;
   logic [15:0] stickyFlags;
   modport store (input clearReq, input rawLevels, output stickyFlags);
   modport user  (output clearReq, output rawLevels, input stickyFlags);
endinterface

// ### rtl/sticky_flag_store.sv
// Sticky latches for the summary word bits and the output status bits
`timescale 1ns/1ps
module sticky_flag_store #(
   parameter int          WIDTH   = 16,
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   input  wire logic     clock,
   input  wire logic     rstSync_n,
   status_flag_if.store  flags
);
   logic [WIDTH-1:0] flag_reg;
   logic [WIDTH-1:0] flag_next;

   // A bit holds until its cause is gone and clear is requested; a live
   // cause wins over the clear so no event is lost.
   assign flag_next = flags.clearReq ? flags.rawLevels[WIDTH-1:0]
                                     : (flag_reg | flags.rawLevels[WIDTH-1:0]); // see [RULE7]

   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         flag_reg <= RST_VAL[WIDTH-1:0];
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flags.stickyFlags = flag_reg;
endmodule

// ### rtl/pmbus_status_summary_regs.sv
// Status summary registers answering read byte / read word commands
//
// Functional notes
// [RULE1] Command 78h read byte returns summary byte
// [RULE2] Bit7 busy, bit6 gate drive disabled
// [RULE3] Bit3 input undervoltage fault, default zero
// [RULE4] Bit2 temperature, bit1 comm error register
// [RULE5] Bit0 flags any other event
// [RULE6] Command 79h read word returns summary word
// [RULE7] Bits stay until fault gone and cleared; bits 7, 6 and 11 (busy, gate drive, power good) follow live state instead
// [RULE8] Word low byte is the summary byte
// [RULE9] Bits 15..12 summarize output, current, input, vendor
// [RULE10] Bit8 flags unlisted event, default zero
// [RULE11] Bit11 is inverted power good, default one
// [RULE12] Command 7Ah read byte returns output status
// [RULE13] Output bit5 is output undervoltage warning
// [RULE14] Reserved bits always read zero
`timescale 1ns/1ps
module pmbus_status_summary_regs (
   input  wire logic       clock,
   input  wire logic       arst_n,
   // Command port from the PMBus protocol engine (same clock domain)
   input  wire logic       cmdValid,
   input  wire logic [7:0] cmdCode,
   input  wire logic       cmdRead,
   input  wire logic       readByteIdx,
   output logic [7:0]      readData,
   output logic            readValid,
   output logic            readIsWord,
   // Fault sources, asynchronous levels
   input  wire logic       busy,
   input  wire logic       gate_drive_disabled,
   input  wire logic       input_undervoltage_fault,
   input  wire logic       tempRegisterSummary,
   input  wire logic       comm_error_register,
   input  wire logic       other_event_flag,
   input  wire logic       outputRegisterSummary,
   input  wire logic       current_register_summary,
   input  wire logic       inputRegisterSummary,
   input  wire logic       vendor_register_summary,
   input  wire logic       power_good_n,
   input  wire logic       unlisted_event_flag,
   input  wire logic       output_undervoltage_warning,
   // Snapshots visible to the rest of the device
   output logic [15:0]     faultWord,
   output logic [7:0]      outputFlags
);
   // ---------------------------------------------
   // Reset release
   // ---------------------------------------------
   logic [1:0] rstPipe_reg;
   logic       rstSync_n;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rstPipe_reg <= 2'h0;
      end else begin
         rstPipe_reg <= {rstPipe_reg[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_reg[1];

   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   localparam int NRAW = 13;
   logic [NRAW-1:0] rawAsync;
   logic [NRAW-1:0] sync1_reg;
   logic [NRAW-1:0] sync2_reg;

   assign rawAsync = {output_undervoltage_warning, unlisted_event_flag, power_good_n,
                      vendor_register_summary, inputRegisterSummary,
                      current_register_summary, outputRegisterSummary,
                      other_event_flag, comm_error_register, tempRegisterSummary,
                      input_undervoltage_fault, gate_drive_disabled, busy};

   // Power good resets to the deasserted level so bit 11 comes up as one
   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         sync1_reg <= 13'h0400;
         sync2_reg <= 13'h0400;
      end else begin
         sync1_reg <= rawAsync;
         sync2_reg <= sync1_reg;
      end
   end

   logic sBusy, sGateOff, sVinUv, sTemp, sCml, sOther;
   logic sOutSum, sIoutSum, sInSum, sVendSum, sPgoodN, sUnlisted, sVoutUv;
   assign {sVoutUv, sUnlisted, sPgoodN, sVendSum, sInSum, sIoutSum, sOutSum,
           sOther, sCml, sTemp, sVinUv, sGateOff, sBusy} = sync2_reg;

   // ---------------------------------------------
   // Raw word assembly
   // ---------------------------------------------
   logic [15:0] rawWord;
   logic [7:0]  rawOut;

   always_comb begin
      rawWord                = 16'h0000;                 // see [RULE14]
      rawWord[status_summary_pkg::BIT_BUSY]      = sBusy;     // see [RULE2]
      rawWord[status_summary_pkg::BIT_GATE_OFF]  = sGateOff;  // see [RULE2]
      rawWord[status_summary_pkg::BIT_VIN_UV]    = sVinUv;    // see [RULE3]
      rawWord[status_summary_pkg::BIT_TEMP]      = sTemp;     // see [RULE4]
      rawWord[status_summary_pkg::BIT_CML]       = sCml;      // see [RULE4]
      rawWord[status_summary_pkg::BIT_OTHER]     = sOther;    // see [RULE5]
      // The output status byte lives in this block, so its flag feeds bit 15 too
      rawWord[status_summary_pkg::BIT_OUT_SUM]   = sOutSum | sVoutUv; // see [RULE9]
      rawWord[status_summary_pkg::BIT_IOUT_SUM]  = sIoutSum;  // see [RULE9]
      rawWord[status_summary_pkg::BIT_INPUT_SUM] = sInSum;    // see [RULE9]
      rawWord[status_summary_pkg::BIT_VEND_SUM]  = sVendSum;  // see [RULE9]
      rawWord[status_summary_pkg::BIT_PGOOD_N]   = sPgoodN;   // see [RULE11]
      rawWord[status_summary_pkg::BIT_UNLISTED]  = sUnlisted; // see [RULE10]
      rawOut                 = 8'h00;                    // see [RULE14]
      rawOut[status_summary_pkg::BIT_VOUT_UV]    = sVoutUv;   // see [RULE13]
   end

   // ---------------------------------------------
   // Sticky storage
   // ---------------------------------------------
   status_flag_if wordIf ();
   status_flag_if outIf ();
   logic clearFaults;

   // Busy, gate drive and power good reflect live state; the rest latch until cleared
   assign clearFaults = cmdValid && !cmdRead
                        && (cmdCode == status_summary_pkg::CMD_CLEAR_FAULTS);
   assign wordIf.clearReq  = clearFaults;
   assign wordIf.rawLevels = rawWord;
   assign outIf.clearReq   = clearFaults;
   assign outIf.rawLevels  = {8'h00, rawOut};

   sticky_flag_store #(
      .WIDTH   (16),
      .RST_VAL (status_summary_pkg::RST_FAULT_WORD)
   ) wordStore (
      .clock     (clock),
      .rstSync_n (rstSync_n),
      .flags     (wordIf)
   );

   sticky_flag_store #(
      .WIDTH   (16),
      .RST_VAL ({8'h00, status_summary_pkg::RST_OUTPUT_FLAGS})
   ) outStore (
      .clock     (clock),
      .rstSync_n (rstSync_n),
      .flags     (outIf)
   );

   logic [15:0] wordView;
   always_comb begin
      wordView = wordIf.stickyFlags & 16'hF9CF;          // see [RULE14]
      wordView[status_summary_pkg::BIT_BUSY]     = sBusy;
      wordView[status_summary_pkg::BIT_GATE_OFF] = sGateOff;
      wordView[status_summary_pkg::BIT_PGOOD_N]  = sPgoodN;  // see [RULE11]
   end

   logic [7:0] outView;
   assign outView = outIf.stickyFlags[7:0] & 8'h20;       // see [RULE14]

   // ---------------------------------------------
   // Read decode
   // ---------------------------------------------
   function automatic logic isCmd(input logic [7:0] code, input logic [7:0] ref_code);
      return code == ref_code;
   endfunction

   logic hitByte, hitWord, hitOut, readReq;
   logic [7:0] readSel;
   assign readReq = cmdValid && cmdRead;
   assign hitByte = isCmd(cmdCode, status_summary_pkg::CMD_CRIT_SUMMARY); // see [RULE1]
   assign hitWord = isCmd(cmdCode, status_summary_pkg::CMD_FAULT_WORD);   // see [RULE6]
   assign hitOut  = isCmd(cmdCode, status_summary_pkg::CMD_OUTPUT_FLAGS); // see [RULE12]

   // Word low byte and summary byte come from one store
   assign readSel = hitByte ? wordView[7:0] :                              // see [RULE8]
                    hitWord ? (readByteIdx ? wordView[15:8] : wordView[7:0]) :
                    hitOut  ? outView :
                    status_summary_pkg::UNMAPPED_DATA;

   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         readData   <= 8'h00;
         readValid  <= 1'b0;
         readIsWord <= 1'b0;
      end else begin
         readValid  <= readReq;
         readIsWord <= readReq && hitWord;
         if (readReq) begin
            readData <= readSel;
         end
      end
   end

   assign faultWord   = wordView;
   assign outputFlags = outView;
endmodule

// ### sim/status_summary_checker.sv
// Concurrent checks on the status summary register ports
`timescale 1ns/1ps
module status_summary_checker (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        cmdValid,
   input wire logic [7:0]  cmdCode,
   input wire logic        cmdRead,
   input wire logic        readByteIdx,
   input wire logic [7:0]  readData,
   input wire logic        readValid,
   input wire logic        readIsWord,
   input wire logic        busy,
   input wire logic        input_undervoltage_fault,
   input wire logic        power_good_n,
   input wire logic [15:0] faultWord,
   input wire logic [7:0]  outputFlags
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire rdReq  = cmdValid && cmdRead;
   wire clrReq = cmdValid && !cmdRead && cmdCode == status_summary_pkg::CMD_CLEAR_FAULTS;
   property p_answer; rdReq |=> readValid && readIsWord == ($past(cmdCode) == 8'h79); endproperty
   a_answer: assert property (p_answer) else $error("read answer missing");
   property p_quiet; !rdReq |=> !readValid; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without read");
   property p_crit; rdReq && cmdCode == 8'h78 |=> readData == $past(faultWord[7:0]); endproperty
   a_crit: assert property (p_crit) else $error("summary byte differs");
   property p_hi; rdReq && cmdCode == 8'h79 && readByteIdx |=> readData == $past(faultWord[15:8]);
   endproperty
   a_hi: assert property (p_hi) else $error("word high byte differs");
   property p_out; rdReq && cmdCode == 8'h7A |=> readData == $past(outputFlags); endproperty
   a_out: assert property (p_out) else $error("output flags differ");
   property p_resv;
      (faultWord & 16'h0630) == 16'h0000 && (outputFlags & 8'hDF) == 8'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   property p_busy; busy [*8] |-> faultWord[7]; endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_pgood; $stable(power_good_n) [*8] |-> faultWord[11] == power_good_n; endproperty
   a_pgood: assert property (p_pgood) else $error("power good bit wrong");
   property p_vinuv;
      $rose(faultWord[3]) |-> $past(input_undervoltage_fault, 2) ||
         $past(input_undervoltage_fault, 3) || $past(input_undervoltage_fault, 4);
   endproperty
   a_vinuv: assert property (p_vinuv) else $error("undervoltage bit without cause");
   // Clear takes effect one cycle later; the clear cycle and the two after it are exempt
   property p_sticky;
      !clrReq && !$past(clrReq) && !$past(clrReq, 2) |=>
         (faultWord & $past(faultWord) & 16'hF10F) == ($past(faultWord) & 16'hF10F);
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky bit lost");
   property p_outsum; outputFlags != 8'h00 |-> faultWord[15]; endproperty
   a_outsum: assert property (p_outsum) else $error("output summary bit missing");
   c_word: cover property (rdReq && cmdCode == 8'h79 && readByteIdx);
   c_clear: cover property (clrReq && faultWord[3]);
   c_hold: cover property (faultWord[3] && !input_undervoltage_fault);
   c_outsum: cover property (rdReq && cmdCode == 8'h7A && outputFlags[5]);
endmodule
bind pmbus_status_summary_regs status_summary_checker u_status_summary_checker (
   .clock(clock), .arst_n(arst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
   .cmdRead(cmdRead), .readByteIdx(readByteIdx), .readData(readData),
   .readValid(readValid), .readIsWord(readIsWord), .busy(busy),
   .input_undervoltage_fault(input_undervoltage_fault), .power_good_n(power_good_n),
   .faultWord(faultWord), .outputFlags(outputFlags));

// ### sim/host_model.sv
// Host-side model issuing requests on the command port
`timescale 1ns/1ps
module host_model (
   input  wire logic       clock,
   output logic            cmdValid,
   output logic [7:0]      cmdCode,
   output logic            cmdRead,
   output logic            readByteIdx,
   input  wire logic [7:0] readData,
   input  wire logic       readValid,
   input  wire logic       readIsWord
);
   initial begin
      cmdValid = 1'b0;
      cmdCode = 8'hFF;
      cmdRead = 1'b0;
      readByteIdx = 1'b0;
   end
   // Released code and byte index lines show the inverse so stale values cannot pass
   task automatic send(input logic [7:0] c, input logic r, input logic i);
      @(posedge clock);
      cmdValid <= 1'b1;
      cmdCode <= c;
      cmdRead <= r;
      readByteIdx <= i;
      @(posedge clock);
      cmdValid <= 1'b0;
      cmdCode <= ~c;
      readByteIdx <= ~i;
   endtask
   task automatic rd(input logic [7:0] c, input logic i, output logic [7:0] d,
                     output logic v, output logic w);
      send(c, 1'b1, i);
      #1;
      d = readData;
      v = readValid;
      w = readIsWord;
   endtask
   task automatic clr();
      send(status_summary_pkg::CMD_CLEAR_FAULTS, 1'b0, 1'b0);
   endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the status summary registers
`timescale 1ns/1ps
module testbench;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [12:0] src = 13'h0000;
   logic [12:0] s;
   logic        cmdValid, cmdRead, readByteIdx, readValid, readIsWord;
   logic [7:0]  cmdCode, readData, outputFlags;
   logic [15:0] faultWord;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          seed = 32'hB27F;
   always #10 clock = ~clock;
   pmbus_status_summary_regs u_pmbus_status_summary_regs (.clock(clock), .arst_n(arst_n),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdRead(cmdRead), .readByteIdx(readByteIdx),
      .readData(readData), .readValid(readValid), .readIsWord(readIsWord), .busy(src[0]),
      .gate_drive_disabled(src[1]), .input_undervoltage_fault(src[2]),
      .tempRegisterSummary(src[3]), .comm_error_register(src[4]), .other_event_flag(src[5]),
      .outputRegisterSummary(src[6]), .current_register_summary(src[7]),
      .inputRegisterSummary(src[8]), .vendor_register_summary(src[9]),
      .power_good_n(src[10]), .unlisted_event_flag(src[11]),
      .output_undervoltage_warning(src[12]), .faultWord(faultWord), .outputFlags(outputFlags));
   host_model u_host_model (.clock(clock), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdRead(cmdRead), .readByteIdx(readByteIdx), .readData(readData),
      .readValid(readValid), .readIsWord(readIsWord));
   // ----------------------------------------
   // Expectation and checking helpers
   // ----------------------------------------
   function automatic logic [23:0] expv(input logic [12:0] t);
      return {t[6] | t[12], t[7], t[8], t[9], t[10], 2'b00, t[11], t[0], t[1], 2'b00,
              t[2], t[3], t[4], t[5], 2'b00, t[12], 5'h00};
   endfunction
   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic readAll(input logic [12:0] t);
      logic [7:0]  d;
      logic        v, w;
      logic [23:0] e;
      e = expv(t);
      u_host_model.rd(8'h78, 1'b0, d, v, w);
      chk("critSummary", {v, w, d}, {2'b10, e[15:8]});
      u_host_model.rd(8'h79, 1'b0, d, v, w);
      chk("wordLow", {v, w, d}, {2'b11, e[15:8]});
      u_host_model.rd(8'h79, 1'b1, d, v, w);
      chk("wordHigh", {v, w, d}, {2'b11, e[23:16]});
      u_host_model.rd(8'h7A, 1'b0, d, v, w);
      chk("outFlags", {v, w, d}, {2'b10, e[7:0]});
      u_host_model.rd(8'h55, 1'b0, d, v, w);
      chk("unmapped", {v, w, d}, {2'b10, status_summary_pkg::UNMAPPED_DATA});
   endtask
   task automatic setSrc(input logic [12:0] t);
      @(posedge clock);
      src <= t;
      repeat (8) @(posedge clock);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge clock);
      chk("resetWord", {2'b00, faultWord[15:8]}, 10'h008);
      chk("resetLow", {2'b00, faultWord[7:0]}, 10'h000);
      chk("resetOut", {2'b00, outputFlags}, 10'h000);
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (8) @(posedge clock);
      readAll(13'h0000);
      for (int i = 0; i < 13; i++) begin
         setSrc(13'h0001 << i);
         readAll(13'h0001 << i);
         setSrc(13'h0000);
         // Neither a read of the clear code nor another write may clear
         u_host_model.send(status_summary_pkg::CMD_CLEAR_FAULTS, 1'b1, 1'b0);
         u_host_model.send(8'h79, 1'b0, 1'b0);
         readAll(13'h1BFC & (13'h0001 << i));
         u_host_model.clr();
         repeat (4) @(posedge clock);
         readAll(13'h0000);
      end
      for (int k = 0; k < 20; k++) begin
         s = 13'($random(seed));
         setSrc(s);
         u_host_model.clr();
         repeat (4) @(posedge clock);
         readAll(s);
      end
      // Reset in mid-run drops every latched flag while all sources are high
      setSrc(13'h1FFF);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk("midResetWord", {2'b00, faultWord[15:8]}, 10'h008);
      chk("midResetOut", {2'b00, outputFlags}, 10'h000);
      arst_n <= 1'b1;
      repeat (8) @(posedge clock);
      readAll(13'h1FFF);
      print_verdict();
   end
endmodule
